// ===== hw/bol_pkg.sv
// Constants for the burst order and latency block
package bol_pkg;
    localparam int ADDR_W = 32;
    // Configuration word layout
    localparam int LAT_MSB = 7;
    localparam int LAT_LSB = 4;
    localparam int FIXED_BIT = 3;
    localparam int HYBRID_BIT = 2;
    localparam int BLEN_MSB = 1;
    localparam int BLEN_LSB = 0;
    // Reset value: latency code 0010, fixed latency on, legacy wrap, 32 words
    localparam logic [15:0] CFG_RESET = 16'h8f2f;
    // Latency codes
    localparam logic [3:0] LAT_CODE_5 = 4'h0;
    localparam logic [3:0] LAT_CODE_6 = 4'h1;
    localparam logic [3:0] LAT_CODE_7 = 4'h2;
    localparam logic [3:0] LAT_CODE_3 = 4'he;
    localparam logic [3:0] LAT_CODE_4 = 4'hf;
    localparam logic [3:0] LAT_CLK_3 = 4'h3;
    localparam logic [3:0] LAT_CLK_4 = 4'h4;
    localparam logic [3:0] LAT_CLK_5 = 4'h5;
    localparam logic [3:0] LAT_CLK_6 = 4'h6;
    localparam logic [3:0] LAT_CLK_7 = 4'h7;
    // Burst length codes
    localparam logic [1:0] BLEN_128 = 2'h0;
    localparam logic [1:0] BLEN_64 = 2'h1;
    localparam logic [1:0] BLEN_16 = 2'h2;
    localparam logic [1:0] BLEN_32 = 2'h3;
    // Wrap masks in word-address units (x16 addressing: half the word count)
    localparam logic [ADDR_W-1:0] MASK_128 = 32'h0000003f;
    localparam logic [ADDR_W-1:0] MASK_64 = 32'h0000001f;
    localparam logic [ADDR_W-1:0] MASK_32 = 32'h0000000f;
    localparam logic [ADDR_W-1:0] MASK_16 = 32'h00000007;
    // AXI4-Lite register offsets
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_REFRESH = 8'h08;
    localparam int ST_BUSY = 0;
    localparam int ST_DOUBLE = 1;
    localparam int ST_STROBE = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD = 2'b01,
        ST_LAT = 2'b11,
        ST_DATA = 2'b10
    } bol_state_t;
endpackage

// ===== hw/bol_burst_order_and_latency.sv
// Burst address sequencer and initial-latency signalling, link-clock sampled
`timescale 1ns/100ps
`default_nettype none
module bol_burst_order_and_latency
    import bol_pkg::*;
(
    input wire logic i_clk,                    // System clock, 125 MHz
    input wire logic i_reset_n,                // Async reset, active low
    input wire logic i_link_clk,               // Host interface clock pin
    input wire logic i_cs_n,                   // Chip select pin, active low
    input wire logic i_cmd_read,               // Command is a read
    input wire logic i_cmd_reg,                // Command targets register space
    input wire logic i_burst_type_bit,         // 1 linear, 0 wrapped
    input wire logic [ADDR_W-1:0] i_cmd_addr,  // Command start word address
    input wire logic [15:0] i_reg_wdata,       // Register write data word
    input wire logic i_refresh_pending,        // Distributed refresh needed
    output logic o_rw_data_strobe,             // Strobe output value
    output logic o_rw_data_strobe_oe,          // Strobe output enable
    output logic [ADDR_W-1:0] o_word_addr,     // Current burst word address
    output logic o_word_valid,                 // Word address advanced, pulse
    output logic o_latency_done,               // Initial latency elapsed, level
    output logic o_refresh_run,                // Array refresh may proceed
    output logic [15:0] o_config_reg_zero,     // Configuration word
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,       // Write address
    input wire logic s_axi_awvalid,            // Write address valid
    output logic s_axi_awready,                // Write address ready
    input wire logic [31:0] s_axi_wdata,       // Write data
    input wire logic [3:0] s_axi_wstrb,        // Write strobes
    input wire logic s_axi_wvalid,             // Write data valid
    output logic s_axi_wready,                 // Write data ready
    output logic [1:0] s_axi_bresp,            // Write response
    output logic s_axi_bvalid,                 // Write response valid
    input wire logic s_axi_bready,             // Write response ready
    input wire logic [7:0] s_axi_araddr,       // Read address
    input wire logic s_axi_arvalid,            // Read address valid
    output logic s_axi_arready,                // Read address ready
    output logic [31:0] s_axi_rdata,           // Read data
    output logic [1:0] s_axi_rresp,            // Read response
    output logic s_axi_rvalid,                 // Read data valid
    input wire logic s_axi_rready              // Read data ready
);

    // Three-stage sampling of the pins
    logic [2:0] clk_sync_ff;
    logic [2:0] cs_sync_ff;
    logic clk_stable_ff;
    logic cs_n_ff;
    logic clk_prev_ff;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clk_sync_ff <= 3'h0;
            cs_sync_ff <= 3'h7;
        end else begin
            clk_sync_ff <= {clk_sync_ff[1:0], i_link_clk};
            cs_sync_ff <= {cs_sync_ff[1:0], i_cs_n};
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clk_stable_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            clk_prev_ff <= 1'b0;
        end else begin
            if (clk_sync_ff[1] == clk_sync_ff[2]) begin
                clk_stable_ff <= clk_sync_ff[2];
            end
            if (cs_sync_ff[1] == cs_sync_ff[2]) begin
                cs_n_ff <= cs_sync_ff[2];
            end
            clk_prev_ff <= clk_stable_ff;
        end
    end

    wire link_edge = clk_stable_ff != clk_prev_ff;
    wire link_rise = clk_stable_ff && !clk_prev_ff;

    // Configuration word
    logic [15:0] cfg_ff;
    assign o_config_reg_zero = cfg_ff;
    wire fixed_lat = cfg_ff[FIXED_BIT];
    wire legacy_wrap = cfg_ff[HYBRID_BIT];

    logic [3:0] lat_clks;
    always_comb begin
        case (cfg_ff[LAT_MSB:LAT_LSB])
            LAT_CODE_5: lat_clks = LAT_CLK_5;
            LAT_CODE_6: lat_clks = LAT_CLK_6;
            LAT_CODE_7: lat_clks = LAT_CLK_7;
            LAT_CODE_3: lat_clks = LAT_CLK_3;
            LAT_CODE_4: lat_clks = LAT_CLK_4;
            default: lat_clks = LAT_CLK_7;
        endcase
    end

    logic [ADDR_W-1:0] wrap_mask;
    always_comb begin
        case (cfg_ff[BLEN_MSB:BLEN_LSB])
            BLEN_128: wrap_mask = MASK_128;
            BLEN_64: wrap_mask = MASK_64;
            BLEN_16: wrap_mask = MASK_16;
            BLEN_32: wrap_mask = MASK_32;
            default: wrap_mask = MASK_32;
        endcase
    end

    // Transaction sequencer
    bol_state_t state_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] start_ff;
    logic [ADDR_W-1:0] mask_ff;
    logic linear_ff;
    logic legacy_ff;
    logic wrapped_ff;
    logic double_ff;
    logic regwr_ff;
    logic [4:0] lat_cnt_ff;
    logic strobe_ff;
    logic strobe_oe_ff;
    logic valid_ff;
    logic [15:0] regw_cap_ff;

    logic [ADDR_W-1:0] step_addr;
    logic nxt_wrapped;
    wire at_top = (addr_ff & mask_ff) == mask_ff;
    // Wrap ends on the word before the start; a start at the base ends at the top
    wire wrap_done = !linear_ff && !legacy_ff && (wrapped_ff || at_top) &&
        (((addr_ff + 32'h1) & mask_ff) == (start_ff & mask_ff));
    always_comb begin
        nxt_wrapped = wrapped_ff;
        if (linear_ff) begin
            step_addr = addr_ff + 32'h1;
        end else if ((addr_ff & mask_ff) == mask_ff) begin
            step_addr = addr_ff & ~mask_ff;
        end else begin
            step_addr = addr_ff + 32'h1;
        end
        if (wrap_done) begin
            // Wrap complete: continue after group end
            step_addr = (start_ff | mask_ff) + 32'h1;
            nxt_wrapped = 1'b0;
        end
        if (!linear_ff && (addr_ff & mask_ff) == mask_ff) begin
            nxt_wrapped = 1'b1;
        end
    end

    wire need_lat = !(i_cmd_reg && !i_cmd_read);
    wire want_double = fixed_lat || i_refresh_pending;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= ST_IDLE;
            addr_ff <= 32'h0;
            start_ff <= 32'h0;
            mask_ff <= 32'h0;
            linear_ff <= 1'b1;
            legacy_ff <= 1'b1;
            wrapped_ff <= 1'b0;
            double_ff <= 1'b0;
            regwr_ff <= 1'b0;
            lat_cnt_ff <= 5'h0;
            strobe_ff <= 1'b0;
            strobe_oe_ff <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= 1'b0;
            if (cs_n_ff) begin
                // Chip select high ends any burst
                state_ff <= ST_IDLE;
                strobe_oe_ff <= 1'b0;
                strobe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        state_ff <= ST_CMD;
                        strobe_oe_ff <= 1'b1;
                        // Strobe level in command phase signals latency
                        strobe_ff <= want_double;
                    end
                    ST_CMD: begin
                        if (link_rise) begin
                            addr_ff <= i_cmd_addr;
                            start_ff <= i_cmd_addr;
                            mask_ff <= wrap_mask;
                            linear_ff <= i_burst_type_bit;
                            legacy_ff <= legacy_wrap;
                            wrapped_ff <= 1'b0;
                            regwr_ff <= !need_lat;
                            double_ff <= strobe_ff;
                            // One or two periods of the latency count
                            lat_cnt_ff <= strobe_ff ? {lat_clks, 1'b0} : {1'b0, lat_clks};
                            strobe_oe_ff <= 1'b0;
                            // Register write skips latency
                            state_ff <= need_lat ? ST_LAT : ST_DATA;
                        end
                    end
                    ST_LAT: begin
                        if (link_rise) begin
                            if (lat_cnt_ff <= 5'h1) begin
                                state_ff <= ST_DATA;
                            end
                            lat_cnt_ff <= lat_cnt_ff - 5'h1;
                        end
                    end
                    ST_DATA: begin
                        if (link_edge && !regwr_ff) begin
                            addr_ff <= step_addr;
                            wrapped_ff <= nxt_wrapped;
                            valid_ff <= 1'b1;
                            if (wrap_done) begin
                                // Rest of a hybrid burst runs linear
                                linear_ff <= 1'b1;
                            end
                        end
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // Register write data capture; refresh not held off by it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            regw_cap_ff <= 16'h0;
        end else if (state_ff == ST_DATA && regwr_ff && link_rise && !cs_n_ff) begin
            regw_cap_ff <= i_reg_wdata;
        end
    end

    assign o_rw_data_strobe = strobe_ff;
    assign o_rw_data_strobe_oe = strobe_oe_ff;
    assign o_word_addr = addr_ff;
    assign o_word_valid = valid_ff;
    assign o_latency_done = (state_ff == ST_DATA);
    assign o_refresh_run = cs_n_ff || (state_ff == ST_DATA && regwr_ff);

    // AXI4-Lite slave
    logic aw_ok_ff;
    logic w_ok_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
    assign s_axi_wready = !w_ok_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    wire wr_go = aw_ok_ff && w_ok_ff;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awaddr_ff <= 8'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            cfg_ff <= CFG_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= RESP_OKAY;
                if (awaddr_ff == REG_CFG) begin
                    if (wstrb_ff[0]) begin
                        cfg_ff[7:0] <= wdata_ff[7:0];
                    end
                    if (wstrb_ff[1]) begin
                        cfg_ff[15:8] <= wdata_ff[15:8];
                    end
                end else if (awaddr_ff != REG_STATUS && awaddr_ff != REG_REFRESH) begin
                    bresp_ff <= RESP_SLVERR;
                end
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            case (s_axi_araddr)
                REG_CFG: rdata_ff <= {16'h0, cfg_ff};
                REG_STATUS: begin
                    rdata_ff <= 32'h0;
                    rdata_ff[ST_BUSY] <= !cs_n_ff;
                    rdata_ff[ST_DOUBLE] <= double_ff;
                    rdata_ff[ST_STROBE] <= strobe_ff;
                end
                REG_REFRESH: rdata_ff <= {16'h0, regw_cap_ff};
                default: begin
                    rdata_ff <= 32'h0;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== test/bol_chk_assertions.sv
// Checker for burst order and latency signalling
`timescale 1ns/100ps
`default_nettype none
module bol_chk
    import bol_pkg::*;
(
    input wire logic i_clk,  // Clock
    input wire logic i_reset_n,  // Reset
    input wire logic i_link_clk,  // Link clock
    input wire logic i_cs_n,  // Select
    input wire logic i_cmd_read,  // Read
    input wire logic i_cmd_reg,  // Register
    input wire logic i_burst_type_bit,  // Linear
    input wire logic i_refresh_pending,  // Refresh
    input wire logic o_rw_data_strobe,  // Strobe
    input wire logic o_rw_data_strobe_oe,  // Strobe enable
    input wire logic [ADDR_W-1:0] o_word_addr,  // Address
    input wire logic o_word_valid,  // Step
    input wire logic o_latency_done,  // Data phase
    input wire logic o_refresh_run,  // Refresh allowed
    input wire logic [15:0] o_config_reg_zero  // Config
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic [ADDR_W-1:0] gm;
    logic wr_reg;
    logic fix;
    assign wr_reg = i_cmd_reg && !i_cmd_read;
    assign fix = o_config_reg_zero[FIXED_BIT];
    always_comb begin
        case (o_config_reg_zero[BLEN_MSB:BLEN_LSB])
            BLEN_128: gm = MASK_128;
            BLEN_64: gm = MASK_64;
            BLEN_16: gm = MASK_16;
            default: gm = MASK_32;
        endcase
    end
    // Next data edge follows five cycles later
    sequence s_step;
        (!o_word_valid) [*4] ##1 o_word_valid;
    endsequence
    property p_linear;
        (o_word_valid && i_burst_type_bit) ##1 s_step |-> o_word_addr == $past(o_word_addr, 5) + 32'h1;
    endproperty
    a_linear: assert property (p_linear) else $error("linear step wrong");
    property p_legacy;
        (o_word_valid && !i_burst_type_bit && o_config_reg_zero[HYBRID_BIT]) ##1 s_step |->
            o_word_addr == (($past(o_word_addr, 5) & ~gm) | (($past(o_word_addr, 5) + 32'h1) & gm));
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy wrap step wrong");
    property p_fixed;
        o_rw_data_strobe_oe && fix |-> o_rw_data_strobe;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed latency strobe low");
    property p_refresh;
        o_rw_data_strobe_oe && !fix && i_refresh_pending |-> o_rw_data_strobe;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh strobe low");
    property p_quiet;
        o_rw_data_strobe_oe && !fix && !i_refresh_pending |-> !o_rw_data_strobe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("variable strobe high");
    property p_reg_now;
        $rose(i_link_clk) && o_rw_data_strobe_oe && !i_cs_n && wr_reg |-> ##[1:8] o_latency_done;
    endproperty
    a_reg_now: assert property (p_reg_now) else $error("register write delayed");
    property p_wait;
        $rose(i_link_clk) && o_rw_data_strobe_oe && !i_cs_n && !wr_reg |=> (!o_latency_done) [*8];
    endproperty
    a_wait: assert property (p_wait) else $error("access without latency");
    property p_ref_run;
        o_latency_done && !i_cs_n && wr_reg |-> o_refresh_run;
    endproperty
    a_ref_run: assert property (p_ref_run) else $error("refresh blocked");
endmodule
bind bol_burst_order_and_latency bol_chk bol_chk_i (
    .i_clk, .i_reset_n, .i_link_clk, .i_cs_n, .i_cmd_read, .i_cmd_reg,
    .i_burst_type_bit, .i_refresh_pending, .o_rw_data_strobe, .o_rw_data_strobe_oe,
    .o_word_addr, .o_word_valid, .o_latency_done, .o_refresh_run, .o_config_reg_zero);
`default_nettype wire

// ===== test/bol_host.sv
// Host controller model driving the link side
`timescale 1ns/100ps
`default_nettype none
module bol_host
    import bol_pkg::*;
(
    input wire logic i_clk,  // Clock
    input wire logic i_rw_data_strobe,  // Strobe
    input wire logic i_rw_data_strobe_oe,  // Strobe enable
    input wire logic i_latency_done,  // Data phase
    output logic o_link_clk,  // Link clock
    output logic o_cs_n,  // Select
    output logic o_cmd_read,  // Read
    output logic o_cmd_reg,  // Register
    output logic o_burst_type_bit,  // Linear
    output logic [ADDR_W-1:0] o_cmd_addr,  // Start address
    output logic [15:0] o_reg_wdata,  // Register data
    output logic o_refresh_pending  // Refresh need
);
    initial begin
        o_link_clk = 1'b0;
        o_cs_n = 1'b1;
        {o_cmd_read, o_cmd_reg, o_burst_type_bit, o_refresh_pending} = 4'h0;
        o_cmd_addr = 32'h0;
        o_reg_wdata = 16'h0;
    end
    // Link clock stands still outside frames; returns rises until data phase
    task automatic run(input logic r, g, l, f, input logic [ADDR_W-1:0] a,
                       input logic [15:0] d, input int n, output int ri, output logic s);
        @(posedge i_clk);
        o_cmd_read <= r;
        o_cmd_reg <= g;
        o_burst_type_bit <= l;
        o_refresh_pending <= f;
        o_cmd_addr <= a;
        o_reg_wdata <= d;
        repeat (2) @(posedge i_clk);
        o_cs_n <= 1'b0;
        repeat (9) @(posedge i_clk);
        @(negedge i_clk);
        s = i_rw_data_strobe_oe && i_rw_data_strobe;
        @(posedge i_clk);
        o_link_clk <= 1'b1;
        ri = 0;
        while (ri < 40) begin
            repeat (5) @(posedge i_clk);
            @(negedge i_clk);
            if (i_latency_done === 1'b1) break;
            @(posedge i_clk);
            o_link_clk <= 1'b0;
            repeat (4) @(posedge i_clk);
            o_link_clk <= 1'b1;
            ri++;
        end
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_link_clk <= ~o_link_clk;
            repeat (4) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_link_clk <= 1'b0;
        @(posedge i_clk);
        o_cmd_addr <= ~a;
        o_reg_wdata <= ~d;
        o_burst_type_bit <= ~l;
        repeat (8) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Top testbench for the burst order and latency block
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import bol_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_link_clk, i_cs_n, i_cmd_read, i_cmd_reg, i_burst_type_bit, i_refresh_pending;
    logic [31:0] i_cmd_addr;
    logic [15:0] i_reg_wdata;
    logic o_rw_data_strobe, o_rw_data_strobe_oe, o_word_valid, o_latency_done;
    logic [31:0] o_word_addr;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int n_errors = 0, checks_done = 0, cycles = 0, seed = 90;
    logic [33:0] aq[$], rq[$];
    logic [1:0] bq[$];
    always #4 i_clk = ~i_clk;
    bol_burst_order_and_latency bol_burst_order_and_latency_i (
        .i_clk, .i_reset_n, .i_link_clk, .i_cs_n, .i_cmd_read, .i_cmd_reg, .i_burst_type_bit,
        .i_cmd_addr, .i_reg_wdata, .i_refresh_pending, .o_rw_data_strobe, .o_rw_data_strobe_oe,
        .o_word_addr, .o_word_valid, .o_latency_done, .o_refresh_run(), .o_config_reg_zero(),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    bol_host bol_host_i (.i_clk, .i_rw_data_strobe(o_rw_data_strobe),
        .i_rw_data_strobe_oe(o_rw_data_strobe_oe), .i_latency_done(o_latency_done),
        .o_link_clk(i_link_clk), .o_cs_n(i_cs_n), .o_cmd_read(i_cmd_read), .o_cmd_reg(i_cmd_reg),
        .o_burst_type_bit(i_burst_type_bit), .o_cmd_addr(i_cmd_addr), .o_reg_wdata(i_reg_wdata),
        .o_refresh_pending(i_refresh_pending));
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] fmask(input logic [1:0] b);
        case (b)
            BLEN_128: return 32'h3f;
            BLEN_64: return 32'h1f;
            BLEN_16: return 32'h07;
            default: return 32'h0f;
        endcase
    endfunction
    function automatic int flat(input logic [3:0] c);
        case (c)
            4'h0: return 5;
            4'h1: return 6;
            4'he: return 3;
            4'hf: return 4;
            default: return 7;
        endcase
    endfunction
    // Word address of data unit k of a burst
    function automatic logic [31:0] fexp(input logic l, h, input logic [31:0] m, st, input int k);
        if (l) return st + 32'(k);
        if (!h || k <= int'(m)) return (st & ~m) | ((st + 32'(k)) & m);
        return (st & ~m) + 32'(k);
    endfunction
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge i_clk);
        bq.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge i_clk);
            if (!ad && s_axi_awready === 1'b1) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready === 1'b1) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge i_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, input logic [33:0] e);
        @(posedge i_clk);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge i_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge i_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    task automatic burst(input logic [15:0] c, input logic r, g, l, f, input logic [7:0] lo,
                         input int n);
        logic [31:0] st;
        logic [31:0] m;
        logic s;
        int ri;
        st = $random(seed);
        st[7:0] = lo;
        m = fmask(c[BLEN_MSB:BLEN_LSB]);
        axw(REG_CFG, {16'h0, c}, RESP_OKAY);
        if (!g) for (int k = 0; k < n; k++) aq.push_back({2'h0, fexp(l, !c[HYBRID_BIT], m, st, k + 1)});
        bol_host_i.run(r, g, l, f, st, st[23:8], n, ri, s);
        check({33'h0, s}, {33'h0, c[FIXED_BIT] || f});
        check(34'(ri), (g && !r) ? 34'h0 : 34'(flat(c[LAT_MSB:LAT_LSB]) * (s ? 2 : 1)));
        check({33'h0, aq.size() == 0}, 34'h1);
        if (g && !r) axr(REG_REFRESH, {RESP_OKAY, 16'h0, st[23:8]});
    endtask
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (o_word_valid === 1'b1 && aq.size() > 0) check({2'h0, o_word_addr}, aq.pop_front());
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (cycles == 40000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        axr(REG_CFG, {RESP_OKAY, 16'h0, 8'h8f, 4'h2, 1'b1, 1'b1, 2'h3});
        axw(REG_CFG, {16'($random(seed)), 16'h8f2f}, RESP_OKAY);
        axr(REG_CFG, {RESP_OKAY, 32'h8f2f});
        axr(8'h0c, {RESP_SLVERR, 32'h0});
        axw(8'h10, 32'h1, RESP_SLVERR);
        axw(REG_STATUS, 32'h0, RESP_OKAY);
        burst(16'h8f2f, 1, 0, 0, 0, 8'h0a, 20);
        burst(16'h8fe0, 1, 0, 0, 0, 8'h03, 70);
        burst(16'h8f01, 0, 0, 0, 1, 8'h2e, 40);
        burst(16'h8f12, 1, 0, 0, 0, 8'h0c, 12);
        burst(16'h8ff3, 1, 0, 0, 1, 8'h0a, 20);
        burst(16'h8f20, 1, 0, 1, 0, 8'h03, 20);
        burst(16'h8f36, 1, 0, 0, 0, 8'h0c, 12);
        burst(16'h8f20, 1, 1, 0, 0, 8'h00, 4);
        burst(16'h8f2e, 0, 1, 0, 1, 8'h00, 4);
        axr(REG_STATUS, {RESP_OKAY, 32'h2});
        end_of_test();
    end
endmodule
`default_nettype wire
